// >>> hdl/usart_sync_master_txrx.sv
// Synchronous master transmit/receive serial port with AXI4-Lite registers.
// Assumes one clock; the serial slave answers on the shared data line.
//
// Overview of operation
// - Shifter reloads from buffer only after last bit.
// - Buffer-to-shifter move takes one cycle, sets empty.
// - Empty flag not software-clearable; buffer write clears.
// - Read-only shifter-empty bit; shifter itself hidden.
// - Transmit interrupt gated by its own enable.
// - Master active needs sync, port and master bits.
// - Clock rate from 16-bit or 8-bit divisor.
// - Transmit enable plus buffer write starts transfer.
// - Ninth transmit bit from register when selected.
// - Single or continuous enable starts reception.
// - Data line sampled on clock falling edge.
// - Single receives one word; continuous until cleared.
// - Both enables set behaves as continuous.
// - Software clears both enables while configuring.
// - Receive-complete flag set; interrupt when enabled.
// - Ninth bit and errors readable in receive status.
// - Low eight received bits in receive buffer.
// - Clearing continuous enable clears latched errors.
// - Master drives clock; port enable claims pins.
// - Polarity bit selects clock idle level.
// - Half-duplex: transmit and receive never overlap.
`timescale 1ns/10ps
`default_nettype none
`include "usart_regs.svh"

module usart_sync_master_txrx
  import usart_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_data_in,
  output pins_out_type serial_pins,
  output logic tx_irq,
  output logic rx_irq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = a[7:0];
    // Upper address bits beyond the byte offset must be zero, so an
    // alias of a register in a wider window answers with an error.
    return ((a >> 8) == '0) && (b[1:0] == 2'h0) &&
           (b <= `OFS_IRQ_CTRL);
  endfunction

  function automatic logic [15:0] divisor(input state_type s);
    return s.wide_divisor_sel ? {s.baud_div_hi, s.baud_div_lo}
                              : {8'h00, s.baud_div_lo};
  endfunction

  // ------------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------------

  state_type st_r;
  state_type st_nxt;
  logic do_write;
  logic do_read;
  logic active;
  logic half_tick;
  logic bit_done;
  logic sample_now;
  logic last_bit;
  logic [3:0] nbits;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [8:0] rx_word;

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  // Address and data are only taken together, which keeps the write
  // path free of holding registers at the cost of waiting for both.

  assign do_write = s_axi_awvalid & s_axi_wvalid & ~st_r.bvalid;
  assign do_read = s_axi_arvalid & ~st_r.rvalid;
  assign s_axi_awready = do_write;
  assign s_axi_wready = do_write;
  assign s_axi_arready = do_read;
  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign serial_pins = st_r.pins;
  // Both requests are levels; they drop only once software has acted.
  assign tx_irq = ~st_r.tx_full & st_r.tx_irq_en;
  assign rx_irq = st_r.rx_done_flag & st_r.rx_irq_en;
  assign wa = s_axi_awaddr[7:0];
  assign ra = s_axi_araddr[7:0];

  // ------------------------------------------------------------------
  // Shift timing
  // ------------------------------------------------------------------

  assign active = st_r.sync_sel & st_r.port_enable &
                  st_r.clock_master_sel;
  assign half_tick = (st_r.baud_cnt == divisor(st_r));
  assign bit_done = half_tick & st_r.phase;
  // The falling edge lands at bit end for idle-low and mid-bit for
  // idle-high; either way one sample is taken per bit.
  assign sample_now = half_tick &
                      (st_r.phase != st_r.clock_idle_polarity);
  assign last_bit = (st_r.bit_cnt == nbits - 4'h1);
  assign rx_word = {st_r.data_sync, st_r.tx_shift_reg[8:1]};

  // The word length follows the engine in use, so a change of the
  // other direction's width cannot cut a word short.
  always_comb begin
    if (st_r.eng == ENG_TX) begin
      nbits = st_r.tx_nine_bit_sel ? 4'h9 : 4'h8;
    end else begin
      nbits = st_r.rx_nine_sel ? 4'h9 : 4'h8;
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------

  always_comb begin
    st_nxt = st_r;
    st_nxt.data_meta = serial_data_in;
    st_nxt.data_sync = st_r.data_meta;

    // Bus answers.
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Shift engine.
    unique case (st_r.eng)
      ENG_IDLE: begin
        st_nxt.baud_cnt = 16'h0000;
        st_nxt.phase = 1'b0;
        st_nxt.bit_cnt = 4'h0;
        if (active && st_r.tx_enable && st_r.tx_full) begin
          st_nxt.tx_shift_reg = {st_r.tx_ninth_bit, st_r.tx_buffer};
          st_nxt.tx_full = 1'b0;
          st_nxt.eng = ENG_TX;
        end else if (active && !st_r.overrun_err &&
                     (st_r.single_rx_en || st_r.continuous_rx_en)) begin
          st_nxt.eng = ENG_RX;
        end
      end
      ENG_TX, ENG_RX: begin
        st_nxt.baud_cnt = half_tick ? 16'h0000 : st_r.baud_cnt + 16'h0001;
        if (half_tick) begin
          st_nxt.phase = ~st_r.phase;
        end
        if (st_r.eng == ENG_RX && sample_now) begin
          st_nxt.tx_shift_reg = rx_word;
        end
        if (bit_done) begin
          st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          if (st_r.eng == ENG_TX) begin
            st_nxt.tx_shift_reg = {1'b0, st_r.tx_shift_reg[8:1]};
          end
        end
        if (bit_done && last_bit) begin
          st_nxt.bit_cnt = 4'h0;
          st_nxt.eng = ENG_IDLE;
          if (st_r.eng == ENG_TX) begin
            if (st_r.tx_full && st_r.tx_enable) begin
              st_nxt.tx_shift_reg = {st_r.tx_ninth_bit, st_r.tx_buffer};
              st_nxt.tx_full = 1'b0;
              st_nxt.eng = ENG_TX;
            end
          end else begin
            if (st_r.rx_done_flag) begin
              // A word not yet read is kept; the new one is dropped.
              st_nxt.overrun_err = 1'b1;
            end else begin
              st_nxt.rx_buffer = st_nxt.tx_shift_reg[8:1];
              st_nxt.rx_ninth_bit = st_nxt.tx_shift_reg[8];
              if (st_r.rx_nine_sel) begin
                st_nxt.rx_buffer = st_nxt.tx_shift_reg[7:0];
              end else begin
                st_nxt.rx_ninth_bit = 1'b0;
              end
              st_nxt.rx_done_flag = 1'b1;
            end
            if (st_r.continuous_rx_en) begin
              // After an overrun the receiver rests until software
              // drops the continuous enable and so clears the error.
              if (!st_nxt.overrun_err) begin
                st_nxt.eng = ENG_RX;
              end
            end else begin
              st_nxt.single_rx_en = 1'b0;
            end
          end
        end
        if (!active || (st_r.eng == ENG_TX && !st_r.tx_enable)) begin
          st_nxt.eng = ENG_IDLE;
        end
      end
      default: begin
        st_nxt.eng = ENG_IDLE;
      end
    endcase

    // Register reads.
    if (do_read) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      st_nxt.rdata = 32'h0000_0000;
      if (mapped(s_axi_araddr)) begin
        unique case (ra)
          `OFS_RX_CTRL_STATUS: st_nxt.rdata[7:0] = {st_r.port_enable,
            st_r.rx_nine_sel, st_r.single_rx_en, st_r.continuous_rx_en,
            2'b00, st_r.overrun_err, st_r.rx_ninth_bit};
          `OFS_TX_BUFFER: st_nxt.rdata[7:0] = st_r.tx_buffer;
          `OFS_TX_CTRL_STATUS: st_nxt.rdata[7:0] = {st_r.clock_master_sel,
            st_r.tx_nine_bit_sel, st_r.tx_enable, st_r.sync_sel, 2'b00,
            st_r.eng != ENG_TX, st_r.tx_ninth_bit};
          `OFS_BAUD_CTRL: st_nxt.rdata[7:0] = {3'b000,
            st_r.clock_idle_polarity, st_r.wide_divisor_sel, 3'b000};
          `OFS_BAUD_DIV_HI: st_nxt.rdata[7:0] = st_r.baud_div_hi;
          `OFS_BAUD_DIV_LO: st_nxt.rdata[7:0] = st_r.baud_div_lo;
          `OFS_OPEN_DRAIN_CTRL: st_nxt.rdata[7:0] =
            {6'h00, st_r.open_drain_ctrl};
          `OFS_RX_BUFFER: begin
            st_nxt.rdata[7:0] = st_r.rx_buffer;
            // A word stored in this same cycle keeps the flag set.
            if (st_nxt.rx_done_flag == st_r.rx_done_flag) begin
              st_nxt.rx_done_flag = 1'b0;
            end
          end
          `OFS_IRQ_CTRL: st_nxt.rdata[7:0] = {4'h0, st_r.rx_done_flag,
            ~st_r.tx_full, st_r.rx_irq_en, st_r.tx_irq_en};
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes.
    // Placed after the engine so a buffer write beats a load in one cycle.
    if (do_write) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (mapped(s_axi_awaddr) && s_axi_wstrb[0]) begin
        unique case (wa)
          `OFS_RX_CTRL_STATUS: begin
            st_nxt.port_enable = s_axi_wdata[`RXB_PORT_ENABLE];
            st_nxt.rx_nine_sel = s_axi_wdata[`RXB_NINE_SEL];
            st_nxt.single_rx_en = s_axi_wdata[`RXB_SINGLE_EN];
            st_nxt.continuous_rx_en = s_axi_wdata[`RXB_CONT_EN];
            if (!s_axi_wdata[`RXB_CONT_EN]) begin
              st_nxt.overrun_err = 1'b0;
            end
          end
          `OFS_TX_BUFFER: begin
            st_nxt.tx_buffer = s_axi_wdata[7:0];
            st_nxt.tx_full = 1'b1;
          end
          `OFS_TX_CTRL_STATUS: begin
            st_nxt.clock_master_sel = s_axi_wdata[`TXB_CLOCK_MASTER];
            st_nxt.tx_nine_bit_sel = s_axi_wdata[`TXB_NINE_SEL];
            st_nxt.tx_enable = s_axi_wdata[`TXB_ENABLE];
            st_nxt.sync_sel = s_axi_wdata[`TXB_SYNC_SEL];
            st_nxt.tx_ninth_bit = s_axi_wdata[`TXB_NINTH_BIT];
          end
          `OFS_BAUD_CTRL: begin
            st_nxt.clock_idle_polarity = s_axi_wdata[`BDB_IDLE_POL];
            st_nxt.wide_divisor_sel = s_axi_wdata[`BDB_WIDE_DIV];
          end
          `OFS_BAUD_DIV_HI: st_nxt.baud_div_hi = s_axi_wdata[7:0];
          `OFS_BAUD_DIV_LO: st_nxt.baud_div_lo = s_axi_wdata[7:0];
          `OFS_OPEN_DRAIN_CTRL: st_nxt.open_drain_ctrl = s_axi_wdata[1:0];
          `OFS_IRQ_CTRL: begin
            st_nxt.tx_irq_en = s_axi_wdata[`IRB_TX_EN];
            st_nxt.rx_irq_en = s_axi_wdata[`IRB_RX_EN];
          end
          default: st_nxt.bresp = `RESP_OKAY;
        endcase
      end
    end

    // Pins: the clock is driven whenever the master port is on, data
    // only while a word goes out, so the line is free for the slave.
    st_nxt.pins.clk_out = st_nxt.clock_idle_polarity ^
                          (st_nxt.eng != ENG_IDLE && st_nxt.phase);
    st_nxt.pins.clk_oe_n = ~(st_nxt.sync_sel & st_nxt.port_enable &
                             st_nxt.clock_master_sel);
    st_nxt.pins.data_out = (st_nxt.eng == ENG_TX) ?
                           st_nxt.tx_shift_reg[0] : 1'b1;
    st_nxt.pins.data_oe_n = ~(st_nxt.eng == ENG_TX &&
      (!st_nxt.open_drain_ctrl[`ODB_PORT1] || !st_nxt.pins.data_out));
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.eng <= ENG_IDLE;
      st_r.baud_div_hi <= `RST_BYTE;
      st_r.baud_div_lo <= `RST_BYTE;
      st_r.pins.clk_oe_n <= 1'b1;
      st_r.pins.data_oe_n <= 1'b1;
      st_r.pins.data_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // usart_sync_master_txrx
`default_nettype wire

// >>> hdl/usart_regs.svh
// Register offsets, bit positions, reset values and bus codes of the
// synchronous master serial port.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
`ifndef USART_REGS_SVH
`define USART_REGS_SVH
`define OFS_RX_CTRL_STATUS 8'h00
`define OFS_TX_BUFFER 8'h04
`define OFS_TX_CTRL_STATUS 8'h08
`define OFS_BAUD_CTRL 8'h0C
`define OFS_BAUD_DIV_HI 8'h10
`define OFS_BAUD_DIV_LO 8'h14
`define OFS_OPEN_DRAIN_CTRL 8'h18
`define OFS_RX_BUFFER 8'h1C
`define OFS_IRQ_CTRL 8'h20
`define RXB_PORT_ENABLE 7
`define RXB_NINE_SEL 6
`define RXB_SINGLE_EN 5
`define RXB_CONT_EN 4
`define TXB_CLOCK_MASTER 7
`define TXB_NINE_SEL 6
`define TXB_ENABLE 5
`define TXB_SYNC_SEL 4
`define TXB_NINTH_BIT 0
`define BDB_IDLE_POL 4
`define BDB_WIDE_DIV 3
`define ODB_PORT1 0
`define IRB_TX_EN 0
`define IRB_RX_EN 1
`define RST_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/usart_pkg.sv
// Types shared by the synchronous master serial port.
// Assumes the constants header is included where offsets are needed.
package usart_pkg;
  typedef enum logic [1:0] {ENG_IDLE, ENG_TX, ENG_RX} engine_type;
  typedef struct packed {
    logic clk_out;
    logic clk_oe_n;
    logic data_out;
    logic data_oe_n;
  } pins_out_type;
  typedef struct packed {
    logic port_enable, rx_nine_sel, single_rx_en, continuous_rx_en;
    logic overrun_err, rx_ninth_bit;
    logic clock_master_sel, tx_nine_bit_sel, tx_enable, sync_sel;
    logic tx_ninth_bit, clock_idle_polarity, wide_divisor_sel;
    logic [7:0] baud_div_hi, baud_div_lo;
    logic [1:0] open_drain_ctrl;
    logic tx_irq_en, rx_irq_en;
    logic [7:0] tx_buffer;
    logic tx_full;
    logic [7:0] rx_buffer;
    logic rx_done_flag;
    engine_type eng;
    logic [8:0] tx_shift_reg;
    logic [3:0] bit_cnt;
    logic phase;
    logic [15:0] baud_cnt;
    logic data_meta, data_sync;
    pins_out_type pins;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_type;
endpackage

// >>> bench/usart_props.sv
// Concurrent checks on the serial port's bus and pin outputs.
// Assumes it is bound to the port module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module usart_props
  import usart_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire pins_out_type serial_pins,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_byte:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_tx_flag_clear:
    assert property ($fell(tx_irq) |-> $past(s_axi_awvalid && s_axi_awready))
    else $error("transmit flag cleared without write");
  a_rx_flag_clear:
    assert property ($fell(rx_irq) |-> $past(s_axi_arvalid &&
      s_axi_arready || s_axi_awvalid && s_axi_awready))
    else $error("receive flag cleared without access");
  a_rx_not_driving:
    assert property ($rose(rx_irq) && !$past(s_axi_awvalid &&
      s_axi_awready) |-> serial_pins.data_oe_n)
    else $error("data driven at receive end");
  a_clock_with_data:
    assert property (!serial_pins.data_oe_n |-> !serial_pins.clk_oe_n)
    else $error("data driven without clock");
  a_data_per_bit:
    assert property (!serial_pins.data_oe_n && $past(!serial_pins.data_oe_n)
      && $stable(serial_pins.clk_out) |-> $stable(serial_pins.data_out))
    else $error("data changed inside a bit");
endmodule // usart_props
bind usart_sync_master_txrx usart_props props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .serial_pins(serial_pins),
  .tx_irq(tx_irq), .rx_irq(rx_irq)
);
`default_nettype wire

// >>> bench/serial_slave_model.sv
// Synchronous serial slave: captures sent bits, shifts out a word.
// Assumes an idle-low clock and a bench that joins the data line.
`timescale 1ns/10ps
`default_nettype none
module serial_slave_model
  import usart_pkg::*;
(
  input wire logic aclk,
  input wire pins_out_type pins,
  input wire logic send_en,
  input wire logic [8:0] send_word,
  output logic data_line,
  output logic [8:0] got_word
);
  // ------------------------------------------------------------
  // Shift logic
  // ------------------------------------------------------------
  logic clk_d = 1'b0;
  logic bit_r = 1'b1;
  logic tg = 1'b0;
  logic [8:0] sh = 9'h000;
  initial got_word = 9'h000;
  // Off-frame the line flips every cycle so stale data never matches.
  assign data_line = send_en ? bit_r : tg;
  always @(posedge aclk) begin
    clk_d <= pins.clk_out;
    tg <= ~tg;
    if (!send_en) begin
      sh <= send_word;
    end else if (pins.clk_out && !clk_d) begin
      bit_r <= sh[0];
      sh <= {1'b0, sh[8:1]};
    end
    if (!pins.data_oe_n && pins.clk_out && !clk_d) begin
      got_word <= {pins.data_out, got_word[8:1]};
    end
  end
endmodule // serial_slave_model
`default_nettype wire

// >>> bench/usart_sync_master_txrx_tb_top.sv
// Register-level bench for the synchronous master serial port.
// Assumes the slave model on the pins; bready and rready held high.
`timescale 1ns/10ps
`default_nettype none
module usart_sync_master_txrx_tb_top
  import usart_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic send_en = 1'b0;
  logic [8:0] send_word = 9'h000;
  logic awr, wrd, bv, arr, rv, txi, rxi, din, sl_d;
  logic [1:0] rr, rd_r, br, wr_b;
  logic [31:0] rdat, rd_d;
  logic [8:0] got;
  pins_out_type pins;
  int busy_cnt, err_count, n_tests;
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    if (pins.data_oe_n === 1'b0) begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  assign din = pins.data_oe_n ? sl_d : pins.data_out;
  usart_sync_master_txrx DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .serial_data_in(din), .serial_pins(pins),
    .tx_irq(txi), .rx_irq(rxi)
  );
  serial_slave_model slave (
    .aclk(aclk), .pins(pins), .send_en(send_en), .send_word(send_word),
    .data_line(sl_d), .got_word(got)
  );
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] sv, ev);
    n_tests++;
    if (sv !== ev) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic hang(input int i, input int lim);
    if (i >= lim) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    i = 0;
    do @(posedge aclk);
    while (!(awr === 1'b1 && wrd === 1'b1) && ++i < 99);
    hang(i, 99);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge aclk); while (bv !== 1'b1 && ++i < 199);
    hang(i, 199);
    wr_b = br;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    int i;
    ara <= a;
    arv <= 1'b1;
    i = 0;
    do @(posedge aclk); while (arr !== 1'b1 && ++i < 99);
    hang(i, 99);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1 && ++i < 199);
    hang(i, 199);
    rd_d = rdat;
    rd_r = rr;
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    k = 0;
    do begin
      bus_rd(a);
      k++;
    end while (rd_d[b] !== 1'b1 && k < 3000);
    hang(k, 3000);
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus_rd(8'h08);
    chk("tx_ctrl_status", rd_d, 32'h02);
    bus_rd(8'h20);
    chk("irq_ctrl", rd_d, 32'h04);
    bus_rd(8'h24);
    chk("unmapped", {30'h0, rd_r}, 32'h2);
    bus_wr(8'h24, 8'h00);
    chk("unmapped write", {30'h0, wr_b}, 32'h2);
    bus_wr(8'h14, 8'h03);
    chk("write okay", {30'h0, wr_b}, 32'h0);
    bus_wr(8'h00, 8'h80);
    bus_wr(8'h20, 8'h01);
    bus_wr(8'h08, 8'hB0);
    busy_cnt = 0;
    bus_wr(8'h04, 8'hA5);
    bus_wr(8'h04, 8'h3C);
    chk("tx_irq full", txi, 1'b0);
    poll(8'h08, 1);
    chk("tx_irq empty", txi, 1'b1);
    chk("two words", busy_cnt, 16 * 2 * 4);
    chk("second word", got[8:1], 8'h3C);
    bus_wr(8'h10, 8'h01);
    bus_wr(8'h0C, 8'h08);
    bus_wr(8'h08, 8'hF1);
    busy_cnt = 0;
    bus_wr(8'h04, 8'h55);
    poll(8'h08, 1);
    chk("wide divisor", busy_cnt, 9 * 2 * 260);
    chk("nine bits", got, 9'h155);
    bus_wr(8'h0C, 8'h00);
    bus_wr(8'h20, 8'h02);
    chk("tx_irq masked", txi, 1'b0);
    send_word <= 9'h06B;
    @(posedge aclk);
    send_en <= 1'b1;
    busy_cnt = 0;
    bus_wr(8'h00, 8'hA0);
    poll(8'h20, 3);
    chk("rx_irq", rxi, 1'b1);
    bus_rd(8'h00);
    chk("single done", rd_d, 32'h80);
    bus_rd(8'h1C);
    chk("rx_buffer", rd_d, 32'h6B);
    chk("rx_irq read", rxi, 1'b0);
    chk("rx no drive", busy_cnt, 0);
    send_en <= 1'b0;
    @(posedge aclk);
    send_en <= 1'b1;
    bus_wr(8'h00, 8'hB0);
    repeat (200) @(posedge aclk);
    bus_rd(8'h00);
    chk("overrun", rd_d, 32'hB2);
    bus_wr(8'h00, 8'h80);
    bus_rd(8'h00);
    chk("error cleared", rd_d, 32'h80);
    bus_rd(8'h1C);
    chk("first kept", rd_d, 32'h6B);
    bus_wr(8'h0C, 8'h10);
    repeat (4) @(posedge aclk);
    chk("idle clock", pins.clk_out, 1'b1);
    wrap_up();
  end
endmodule // usart_sync_master_txrx_tb_top
`default_nettype wire
